// >>> skpx_defines.svh
`ifndef SKPX_DEFINES_SVH
`define SKPX_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SKPX_OFF_CMD 8'h00
`define SKPX_OFF_STATUS 8'h04
`define SKPX_OFF_ACC 8'h08
`define SKPX_OFF_FLAGS 8'h0c
`define SKPX_OFF_TABLE_POINTER_LOW 8'h10
`define SKPX_OFF_TABLE_POINTER_HIGH 8'h14
`define SKPX_OFF_TABLE_HIGH_LATCH 8'h18
`define SKPX_OFF_DADDR 8'h1c
`define SKPX_OFF_DDATA 8'h20
`define SKPX_OFF_PADDR 8'h24
`define SKPX_OFF_PDATA 8'h28

// ----------------------------------------
// Field layouts
// ----------------------------------------
`define SKPX_CMD_OP 3:0
`define SKPX_CMD_BIT 6:4
`define SKPX_CMD_ADDR 12:8
`define SKPX_FLAG_Z 0
`define SKPX_ST_BUSY 0
`define SKPX_ST_SKIP 1
`define SKPX_ST_CYC 5:4

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define SKPX_DMEM_WORDS 32
`define SKPX_PMEM_WORDS 512
`define SKPX_LAST_PAGE 1'h1
`define SKPX_ZERO_BYTE 8'h00
`define SKPX_RST_BYTE 8'h00
`define SKPX_RST_WORD 16'h0000
`define SKPX_CYC_BASE 2'h2
`define SKPX_CYC_SKIP 2'h3
`define SKPX_HTRANS_BUSY_BIT 1

`endif

// >>> skpx_pkg.sv
package skpx_pkg;

    typedef enum logic [3:0] {
        OP_SKIP_IF_BYTE_ZERO = 4'h0,
        OP_COPY_AND_SKIP_IF_ZERO = 4'h1,
        OP_SKIP_IF_BIT_ZERO = 4'h2,
        OP_TABLE_READ_PAGED = 4'h3,
        OP_TABLE_READ_FINAL_PAGE = 4'h4,
        OP_PREINC_TABLE_READ_PAGED = 4'h5,
        OP_PREINC_TABLE_READ_FINAL_PAGE = 4'h6,
        OP_XOR_INTO_ACCUMULATOR = 4'h7,
        OP_XOR_INTO_MEMORY = 4'h8,
        OP_NIBBLE_SWAP_TO_ACCUMULATOR = 4'h9
    } skpx_op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_EXEC = 4'h2,
        ST_WRITE = 4'h4,
        ST_DUMMY = 4'h8
    } skpx_state_t;

endpackage : skpx_pkg

// >>> skpx_alu.sv
`timescale 1ns/1ps
`include "skpx_defines.svh"

module skpx_alu
    import skpx_pkg::*;
(
    input wire logic [3:0] op,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] acc,
    input wire logic [7:0] opnd,
    input wire logic [15:0] pword,
    output logic acc_we,
    output logic [7:0] acc_nxt,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    output logic table_high_latch_we,
    output logic skip,
    output logic z_we,
    output logic z_val
);

    logic [7:0] xor_res;

    assign xor_res = acc ^ opnd;

    always_comb
    begin
        acc_we = 1'b0;
        acc_nxt = acc;
        mem_we = 1'b0;
        mem_wdata = opnd;
        table_high_latch_we = 1'b0;
        skip = 1'b0;
        z_we = 1'b0;
        z_val = (xor_res == `SKPX_ZERO_BYTE);
        case (op)
            OP_SKIP_IF_BYTE_ZERO:
            begin
                mem_we = 1'b1;
                skip = (opnd == `SKPX_ZERO_BYTE);
            end
            OP_COPY_AND_SKIP_IF_ZERO:
            begin
                acc_we = 1'b1;
                acc_nxt = opnd;
                skip = (opnd == `SKPX_ZERO_BYTE);
            end
            OP_SKIP_IF_BIT_ZERO:
            begin
                skip = ~opnd[bit_sel];
            end
            OP_TABLE_READ_PAGED, OP_TABLE_READ_FINAL_PAGE,
            OP_PREINC_TABLE_READ_PAGED, OP_PREINC_TABLE_READ_FINAL_PAGE:
            begin
                mem_we = 1'b1;
                mem_wdata = pword[7:0];
                table_high_latch_we = 1'b1;
            end
            OP_XOR_INTO_ACCUMULATOR:
            begin
                acc_we = 1'b1;
                acc_nxt = xor_res;
                z_we = 1'b1;
            end
            OP_XOR_INTO_MEMORY:
            begin
                mem_we = 1'b1;
                mem_wdata = xor_res;
                z_we = 1'b1;
            end
            OP_NIBBLE_SWAP_TO_ACCUMULATOR:
            begin
                acc_we = 1'b1;
                acc_nxt = {opnd[3:0], opnd[7:4]};
            end
            default:
            begin
                acc_we = 1'b0;
            end
        endcase
    end

endmodule : skpx_alu

// >>> skpx_core.sv
`timescale 1ns/1ps
`include "skpx_defines.svh"

module skpx_core
    import skpx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic busy,
    output logic dummy_cycle
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    skpx_state_t state_ff;
    skpx_state_t nxt_state;
    logic [7:0] dmem [`SKPX_DMEM_WORDS];
    logic [15:0] pmem [`SKPX_PMEM_WORDS];
    logic [3:0] op_ff;
    logic [2:0] bit_ff;
    logic [4:0] m_ff;
    logic [7:0] acc_ff;
    logic [7:0] flags_ff;
    logic [7:0] table_pointer_low_ff;
    logic [7:0] table_pointer_high_ff;
    logic [7:0] table_high_latch_ff;
    logic [7:0] opnd_ff;
    logic [15:0] pword_ff;
    logic skip_ff;
    logic [1:0] cyc_ff;
    logic [4:0] daddr_ff;
    logic [8:0] paddr_ff;
    logic wr_pend_ff;
    logic rd_wait_ff;
    logic [7:0] baddr_ff;
    logic [31:0] hrdata_ff;
    logic addr_ok;
    logic bus_wr;
    logic cmd_go;
    logic preinc;
    logic final_page;
    logic [7:0] ptr_lo;
    logic [31:0] rd_mux;
    logic acc_we;
    logic [7:0] acc_nxt;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic table_high_latch_we;
    logic skip;
    logic z_we;
    logic z_val;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // Reads take one wait state so that a write just before lands first
    assign addr_ok = hsel && hready && htrans[`SKPX_HTRANS_BUSY_BIT];
    assign hreadyout = ce && !rd_wait_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign bus_wr = ce && wr_pend_ff;
    // Software writes to core state are dropped while an instruction runs
    assign cmd_go = bus_wr && (baddr_ff == `SKPX_OFF_CMD) && state_ff == ST_IDLE;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            rd_wait_ff <= 1'b0;
            baddr_ff <= `SKPX_RST_BYTE;
        end
        else if (ce)
        begin
            wr_pend_ff <= addr_ok && hwrite;
            rd_wait_ff <= addr_ok && !hwrite;
            if (addr_ok)
            begin
                baddr_ff <= haddr[7:0];
            end
        end
    end

    always_comb
    begin
        rd_mux = '0;
        case (baddr_ff)
            `SKPX_OFF_CMD: rd_mux = {19'h0, m_ff, 1'b0, bit_ff, op_ff};
            `SKPX_OFF_STATUS: rd_mux = {26'h0, cyc_ff, 2'h0, skip_ff, busy};
            `SKPX_OFF_ACC: rd_mux = {24'h0, acc_ff};
            `SKPX_OFF_FLAGS: rd_mux = {24'h0, flags_ff};
            `SKPX_OFF_TABLE_POINTER_LOW: rd_mux = {24'h0, table_pointer_low_ff};
            `SKPX_OFF_TABLE_POINTER_HIGH: rd_mux = {24'h0, table_pointer_high_ff};
            `SKPX_OFF_TABLE_HIGH_LATCH: rd_mux = {24'h0, table_high_latch_ff};
            `SKPX_OFF_DADDR: rd_mux = {27'h0, daddr_ff};
            `SKPX_OFF_DDATA: rd_mux = {24'h0, dmem[daddr_ff]};
            `SKPX_OFF_PADDR: rd_mux = {23'h0, paddr_ff};
            `SKPX_OFF_PDATA: rd_mux = {16'h0, pmem[paddr_ff]};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_ff <= '0;
        end
        else if (ce && rd_wait_ff)
        begin
            hrdata_ff <= rd_mux;
        end
    end

    // ----------------------------------------
    // Software-visible registers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            op_ff <= OP_SKIP_IF_BYTE_ZERO;
            bit_ff <= '0;
            m_ff <= '0;
            daddr_ff <= '0;
            paddr_ff <= '0;
        end
        else if (bus_wr && state_ff == ST_IDLE)
        begin
            if (baddr_ff == `SKPX_OFF_CMD)
            begin
                op_ff <= hwdata[`SKPX_CMD_OP];
                bit_ff <= hwdata[`SKPX_CMD_BIT];
                m_ff <= hwdata[`SKPX_CMD_ADDR];
            end
            if (baddr_ff == `SKPX_OFF_DADDR)
                daddr_ff <= hwdata[4:0];
            if (baddr_ff == `SKPX_OFF_PADDR)
                paddr_ff <= hwdata[8:0];
        end
    end

    always_ff @(posedge hclk)
    begin
        if (ce && state_ff == ST_WRITE && mem_we)
            dmem[m_ff] <= mem_wdata;
        else if (bus_wr && state_ff == ST_IDLE && baddr_ff == `SKPX_OFF_DDATA)
            dmem[daddr_ff] <= hwdata[7:0];
    end

    always_ff @(posedge hclk)
    begin
        if (bus_wr && state_ff == ST_IDLE && baddr_ff == `SKPX_OFF_PDATA)
            pmem[paddr_ff] <= hwdata[15:0];
    end

    // ----------------------------------------
    // Execution sequence
    // ----------------------------------------
    assign busy = (state_ff != ST_IDLE);
    assign dummy_cycle = (state_ff == ST_DUMMY);
    assign preinc = (op_ff == OP_PREINC_TABLE_READ_PAGED)
        || (op_ff == OP_PREINC_TABLE_READ_FINAL_PAGE);
    assign final_page = (op_ff == OP_TABLE_READ_FINAL_PAGE)
        || (op_ff == OP_PREINC_TABLE_READ_FINAL_PAGE);
    assign ptr_lo = preinc ? 8'(table_pointer_low_ff + 8'h01) : table_pointer_low_ff;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: nxt_state = cmd_go ? ST_EXEC : ST_IDLE;
            ST_EXEC: nxt_state = ST_WRITE;
            ST_WRITE: nxt_state = skip ? ST_DUMMY : ST_IDLE;
            ST_DUMMY: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_ff <= ST_IDLE;
        else if (ce)
            state_ff <= nxt_state;
    end

    // Operand and program word are latched a cycle ahead of the commit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            opnd_ff <= `SKPX_RST_BYTE;
            pword_ff <= `SKPX_RST_WORD;
        end
        else if (ce && state_ff == ST_EXEC)
        begin
            opnd_ff <= dmem[m_ff];
            pword_ff <= pmem[{final_page ? `SKPX_LAST_PAGE : table_pointer_high_ff[0], ptr_lo}];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            table_pointer_low_ff <= `SKPX_RST_BYTE;
            table_pointer_high_ff <= `SKPX_RST_BYTE;
            table_high_latch_ff <= `SKPX_RST_BYTE;
        end
        else if (ce)
        begin
            if (state_ff == ST_EXEC)
                table_pointer_low_ff <= ptr_lo;
            else if (bus_wr && state_ff == ST_IDLE && baddr_ff == `SKPX_OFF_TABLE_POINTER_LOW)
                table_pointer_low_ff <= hwdata[7:0];
            if (bus_wr && state_ff == ST_IDLE && baddr_ff == `SKPX_OFF_TABLE_POINTER_HIGH)
                table_pointer_high_ff <= hwdata[7:0];
            if (state_ff == ST_WRITE && table_high_latch_we)
                table_high_latch_ff <= pword_ff[15:8];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_ff <= `SKPX_RST_BYTE;
            flags_ff <= `SKPX_RST_BYTE;
        end
        else if (ce)
        begin
            if (state_ff == ST_WRITE && acc_we)
                acc_ff <= acc_nxt;
            else if (bus_wr && state_ff == ST_IDLE && baddr_ff == `SKPX_OFF_ACC)
                acc_ff <= hwdata[7:0];
            // Only the zero flag is ever written by an instruction here
            if (state_ff == ST_WRITE && z_we)
                flags_ff[`SKPX_FLAG_Z] <= z_val;
            else if (bus_wr && state_ff == ST_IDLE && baddr_ff == `SKPX_OFF_FLAGS)
                flags_ff <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            skip_ff <= 1'b0;
            cyc_ff <= '0;
        end
        else if (ce && state_ff == ST_WRITE)
        begin
            skip_ff <= skip;
            cyc_ff <= skip ? `SKPX_CYC_SKIP : `SKPX_CYC_BASE;
        end
    end

    skpx_alu u_alu (
        .op(op_ff),
        .bit_sel(bit_ff),
        .acc(acc_ff),
        .opnd(opnd_ff),
        .pword(pword_ff),
        .acc_we(acc_we),
        .acc_nxt(acc_nxt),
        .mem_we(mem_we),
        .mem_wdata(mem_wdata),
        .table_high_latch_we(table_high_latch_we),
        .skip(skip),
        .z_we(z_we),
        .z_val(z_val)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn || !ce);

    sequence s_commit(skpx_op_t o);
        state_ff == ST_WRITE && op_ff == o;
    endsequence

    sequence s_taken;
        state_ff == ST_EXEC ##1 state_ff == ST_WRITE && skip;
    endsequence

    a_byte_skip_zero: assert property (s_commit(OP_SKIP_IF_BYTE_ZERO) |->
        mem_we && mem_wdata == opnd_ff && skip == (opnd_ff == 8'h00))
        else $error("byte skip writeback or zero test wrong");

    a_taken_three_cycles: assert property (s_taken |=> state_ff == ST_DUMMY ##1
        state_ff == ST_IDLE)
        else $error("taken skip not three cycles");

    a_copy_to_acc: assert property (s_commit(OP_COPY_AND_SKIP_IF_ZERO) |=>
        acc_ff == $past(opnd_ff) && (state_ff == ST_DUMMY) == (acc_ff == 8'h00))
        else $error("copy-and-skip wrong");

    a_bit_test_skip: assert property (s_commit(OP_SKIP_IF_BIT_ZERO) |=>
        (state_ff == ST_DUMMY) == !$past(opnd_ff[bit_ff]))
        else $error("bit test skip wrong");

    a_table_read_store: assert property (state_ff == ST_WRITE && table_high_latch_we |->
        mem_we && mem_wdata == pword_ff[7:0] ##1 table_high_latch_ff == $past(pword_ff[15:8]))
        else $error("table read stores wrong");

    a_final_page_addr: assert property (state_ff == ST_EXEC && final_page |=>
        pword_ff == pmem[{1'b1, table_pointer_low_ff}])
        else $error("final page read wrong address");

    a_preinc_pointer: assert property (state_ff == ST_EXEC && preinc |=>
        table_pointer_low_ff == 8'($past(table_pointer_low_ff) + 8'h01))
        else $error("pointer not incremented");

    a_xor_acc_zero: assert property (s_commit(OP_XOR_INTO_ACCUMULATOR) |=>
        acc_ff == ($past(acc_ff) ^ $past(opnd_ff)) && flags_ff[0] == (acc_ff == 8'h00))
        else $error("xor into accumulator wrong");

    a_xor_mem_write: assert property (s_commit(OP_XOR_INTO_MEMORY) |->
        mem_we && mem_wdata == (acc_ff ^ opnd_ff) ##1 acc_ff == $past(acc_ff))
        else $error("xor into memory wrong");

    a_flags_hold: assert property (state_ff == ST_WRITE && !z_we |=>
        flags_ff == $past(flags_ff))
        else $error("flags changed unexpectedly");

    a_nibble_swap: assert property (s_commit(OP_NIBBLE_SWAP_TO_ACCUMULATOR) |->
        !mem_we ##1 acc_ff == {$past(opnd_ff[3:0]), $past(opnd_ff[7:4])})
        else $error("nibble swap wrong");

endmodule : skpx_core

// >>> skip_table_xor_exec_tb.sv
`timescale 1ns/1ps
`include "skpx_defines.svh"

module skip_table_xor_exec_tb
    import skpx_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic hclk = 1'b0;
    logic hresetn, ce, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, busy, dummy_cycle;
    logic rd_dphase = 1'b0;
    logic rdy_s, busy_s, dum_s;
    logic [31:0] rdq[$];
    logic cycq[$];
    logic [31:0] seed = 32'h00016eb0;
    int miscompares = 0;
    int comparisons = 0;
    int bcnt = 0;
    int dcnt = 0;

    always #2 hclk = ~hclk;

    // Outputs settle mid-cycle, so they are taken at the falling edge to avoid edge races
    always @(negedge hclk)
    begin
        rdy_s = hreadyout;
        busy_s = busy;
        dum_s = dummy_cycle;
    end

    // Bus ready is the one slave's own ready
    skpx_core skpx_core_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy),
        .dummy_cycle(dummy_cycle));

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic timed_out(input string what);
        miscompares++;
        $display("BAD %0t %s", $time, what);
        print_verdict();
    endtask : timed_out

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_word

    function automatic logic [7:0] rnd();
        seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
        return seed[7:0];
    endfunction : rnd

    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    task automatic wait_ready(input string what);
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (rdy_s !== 1'b1 && n < 20);
        if (n >= 20)
            timed_out(what);
    endtask : wait_ready

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready("address phase hang");
        htrans <= 2'h0;
        hwdata <= d;
        rd_dphase <= ~w;
        wait_ready("data phase hang");
        rd_dphase <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, {24'h0, d});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rdq.push_back({24'h0, e});
        bus(a, 1'b0, 32'h0);
    endtask : rd

    task automatic set_mem(input logic [4:0] m, input logic [7:0] v);
        wr(`SKPX_OFF_DADDR, {3'h0, m});
        wr(`SKPX_OFF_DDATA, v);
    endtask : set_mem

    task automatic chk_mem(input logic [4:0] m, input logic [7:0] v);
        wr(`SKPX_OFF_DADDR, {3'h0, m});
        rd(`SKPX_OFF_DDATA, v);
    endtask : chk_mem

    // Status is read back so the cycle count also shows in the register view
    task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [4:0] m,
                       input logic sk);
        int n;
        cycq.push_back(sk);
        bus(`SKPX_OFF_CMD, 1'b1, {19'h0, m, 1'b0, b, op});
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (busy_s !== 1'b0 && n < 20);
        if (n >= 20)
            timed_out("instruction hang");
        rd(`SKPX_OFF_STATUS, {2'h0, sk ? 2'h3 : 2'h2, 2'h0, sk, 1'b0});
    endtask : run

    // ----------------------------------------
    // Output watcher
    // ----------------------------------------
    always @(posedge hclk)
    begin
        if (rd_dphase && rdy_s === 1'b1)
        begin
            if (rdq.size() == 0)
                timed_out("read without expectation");
            check_word(hrdata, rdq.pop_front(), "read data");
            check_word({31'h0, hresp}, 32'h0, "response");
        end
        if (busy_s === 1'b1)
        begin
            bcnt = bcnt + 1;
            dcnt = dcnt + ((dum_s === 1'b1) ? 1 : 0);
        end
        else if (bcnt != 0)
        begin
            if (cycq.size() == 0)
                timed_out("instruction without expectation");
            check_word(bcnt, cycq[0] ? 3 : 2, "busy cycles");
            check_word(dcnt, cycq.pop_front() ? 1 : 0, "dummy cycles");
            bcnt = 0;
            dcnt = 0;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] v, f, a, m, t;
        logic [15:0] w[4];
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`SKPX_OFF_ACC, 8'h00);
        rd(`SKPX_OFF_FLAGS, 8'h00);
        rd(`SKPX_OFF_TABLE_POINTER_LOW, 8'h00);
        rd(`SKPX_OFF_TABLE_HIGH_LATCH, 8'h00);
        rd(`SKPX_OFF_STATUS, 8'h00);
        rd(8'h3c, 8'h00);
        // Zero, single low bit, single high bit, then random
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'h80 : rnd();
            f = rnd();
            a = rnd();
            wr(`SKPX_OFF_FLAGS, f);
            wr(`SKPX_OFF_ACC, a);
            set_mem(5'(i + 3), v);
            run(OP_SKIP_IF_BYTE_ZERO, 3'h0, 5'(i + 3), v == 8'h00);
            chk_mem(5'(i + 3), v);
            rd(`SKPX_OFF_ACC, a);
            rd(`SKPX_OFF_FLAGS, f);
            run(OP_COPY_AND_SKIP_IF_ZERO, 3'h0, 5'(i + 3), v == 8'h00);
            rd(`SKPX_OFF_ACC, v);
            rd(`SKPX_OFF_FLAGS, f);
        end
        v = rnd();
        v[0] = 1'b0;
        v[1] = 1'b1;
        set_mem(5'h07, v);
        for (int b = 0; b < 8; b++)
            run(OP_SKIP_IF_BIT_ZERO, 3'(b), 5'h07, ~v[b]);
        chk_mem(5'h07, v);
        rd(`SKPX_OFF_FLAGS, f);
        // Pointer at 0xff makes the pre-increment wrap to 0x00
        t = rnd();
        wr(`SKPX_OFF_TABLE_POINTER_HIGH, {t[7:1], 1'b0});
        for (int k = 0; k < 4; k++)
        begin
            w[k] = {rnd(), rnd()};
            wr(`SKPX_OFF_PADDR, k[1] ? 8'h00 : 8'hff);
            bus(`SKPX_OFF_PADDR, 1'b1, {23'h0, k[0], k[1] ? 8'h00 : 8'hff});
            bus(`SKPX_OFF_PDATA, 1'b1, {16'h0, w[k]});
        end
        for (int k = 0; k < 4; k++)
        begin
            f = rnd();
            wr(`SKPX_OFF_TABLE_POINTER_LOW, 8'hff);
            wr(`SKPX_OFF_FLAGS, f);
            run(4'(k + 3), 3'h0, 5'(k + 9), 1'b0);
            chk_mem(5'(k + 9), w[k][7:0]);
            rd(`SKPX_OFF_TABLE_HIGH_LATCH, w[k][15:8]);
            rd(`SKPX_OFF_TABLE_POINTER_LOW, k[1] ? 8'h00 : 8'hff);
            rd(`SKPX_OFF_FLAGS, f);
        end
        // Second pass uses equal operands so the zero flag must set
        for (int i = 0; i < 2; i++)
        begin
            a = rnd();
            m = (i == 1) ? a : rnd();
            f = rnd();
            wr(`SKPX_OFF_ACC, a);
            wr(`SKPX_OFF_FLAGS, f);
            set_mem(5'h0c, m);
            run(OP_XOR_INTO_ACCUMULATOR, 3'h0, 5'h0c, 1'b0);
            rd(`SKPX_OFF_ACC, a ^ m);
            rd(`SKPX_OFF_FLAGS, {f[7:1], (a ^ m) == 8'h00});
            chk_mem(5'h0c, m);
            wr(`SKPX_OFF_ACC, a);
            wr(`SKPX_OFF_FLAGS, ~f);
            run(OP_XOR_INTO_MEMORY, 3'h0, 5'h0c, 1'b0);
            chk_mem(5'h0c, a ^ m);
            rd(`SKPX_OFF_ACC, a);
            rd(`SKPX_OFF_FLAGS, {~f[7:1], (a ^ m) == 8'h00});
        end
        v = rnd();
        set_mem(5'h0d, v);
        run(OP_NIBBLE_SWAP_TO_ACCUMULATOR, 3'h0, 5'h0d, 1'b0);
        rd(`SKPX_OFF_ACC, {v[3:0], v[7:4]});
        chk_mem(5'h0d, v);
        repeat (4) @(posedge hclk);
        if (rdq.size() != 0 || cycq.size() != 0)
            timed_out("results missing");
        print_verdict();
    end

endmodule : skip_table_xor_exec_tb
